// ### pkg/memclk_pkg.sv
// constants for the memory clock counter, alarms and recovery modules
package memclk_pkg;

    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [11:0] STATUS_ADDR  = 12'h702;
    localparam logic [11:0] IE_ADDR      = 12'h704;
    localparam logic [11:0] CNT_HI_ADDR  = 12'h708;
    localparam logic [11:0] CNT_LO_ADDR  = 12'h70A;
    localparam logic [11:0] ALARM0_ADDR  = 12'h70C;
    localparam logic [11:0] ALARM1_ADDR  = 12'h70E;
    localparam logic [11:0] CTRL_A_ADDR  = 12'h710;
    localparam logic [11:0] WHOLE_A_ADDR = 12'h712;
    localparam logic [11:0] FRAC_A_ADDR  = 12'h714;
    localparam logic [11:0] CTRL_B_ADDR  = 12'h718;
    localparam logic [11:0] WHOLE_B_ADDR = 12'h71A;
    localparam logic [11:0] FRAC_B_ADDR  = 12'h71C;

    // ****************************************
    // control register fields
    // ****************************************
    localparam int DECIM_W   = 10;
    localparam int CLR_BIT   = 10;
    localparam int SRC_LSB   = 11;
    localparam int LOAD_BIT  = 13;
    localparam int CTRL_W    = 13;
    localparam logic [12:0] CTRL_RST    = 13'h0001;
    localparam logic [15:0] WHOLE_A_RST = 16'h0002;
    localparam logic [15:0] WHOLE_B_RST = 16'h0000;
    localparam logic [15:0] FRAC_RST    = 16'h0000;
    localparam logic [15:0] WHOLE_MIN   = 16'h0002;

    // ****************************************
    // status and enable bits
    // ****************************************
    localparam int ALARM0_BIT = 0;
    localparam int ALARM1_BIT = 1;
    localparam int LOST_A_BIT = 6;
    localparam int LOST_B_BIT = 7;
    localparam logic [15:0] STATUS_MASK = 16'h00C3;

    // event source codes
    typedef enum logic [1:0] {
        SRC_PULSE = 2'h0,
        SRC_ANY   = 2'h1,
        SRC_RISE  = 2'h2,
        SRC_FALL  = 2'h3
    } src_e;

endpackage : memclk_pkg

// ### src/frac_divider.sv
// fractional divider of the memory clock, one tick per period
`timescale 1ns/1ps
`default_nettype none
module frac_divider (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    // control
    input  wire logic        clear_n,
    input  wire logic        load,
    input  wire logic [15:0] whole_in,
    input  wire logic [15:0] frac_in,
    // recovered timing
    output logic             tick
);
    parameter logic [15:0] WHOLE_RST = memclk_pkg::WHOLE_A_RST;

    typedef struct packed {
        logic [15:0] whole;
        logic [15:0] frac;
        logic [15:0] cnt;
        logic [15:0] acc;
        logic        carry;
        logic        tick;
    } div_s;

    div_s st_q;
    div_s st_d;
    logic [15:0] w_eff;
    logic [16:0] sum;

    // period is whole plus fraction carried in by the accumulator
    always_comb begin
        st_d = st_q;
        st_d.tick = 1'b0;
        w_eff = (st_q.whole < memclk_pkg::WHOLE_MIN) ?
                memclk_pkg::WHOLE_MIN : st_q.whole;
        sum = {1'b0, st_q.acc} + {1'b0, st_q.frac};
        if (load) begin
            st_d.whole = whole_in;
            st_d.frac  = frac_in;
        end
        if (!clear_n) begin
            st_d.cnt   = 16'h0000;
            st_d.acc   = 16'h0000;
            st_d.carry = 1'b0;
        end else if ({1'b0, st_q.cnt} + 17'h0_0001 >=
                     {1'b0, w_eff} + {16'h0000, st_q.carry}) begin
            st_d.cnt   = 16'h0000;
            st_d.acc   = sum[15:0];
            st_d.carry = sum[16];
            st_d.tick  = 1'b1;
        end else begin
            st_d.cnt = st_q.cnt + 16'h0001;
        end
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_q <= '{WHOLE_RST, memclk_pkg::FRAC_RST, 16'h0000,
                      16'h0000, 1'b0, 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign tick = st_q.tick;
endmodule : frac_divider
`default_nettype wire

// ### src/recovery_point.sv
// event source select, decimation and point capture for one module
`timescale 1ns/1ps
`default_nettype none
module recovery_point (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    // event inputs
    input  wire logic        recov_pulse,
    input  wire logic        gpio,
    // control
    input  wire logic [1:0]  source,
    input  wire logic [9:0]  decim,
    input  wire logic [31:0] cnt,
    // point output
    input  wire logic        point_ready,
    output logic             point_valid,
    output logic [31:0]      point_time,
    output logic             point_lost
);
    typedef struct packed {
        logic        gpio;
        logic [9:0]  dcnt;
        logic        valid;
        logic [31:0] ptime;
        logic        lost;
    } pt_s;

    pt_s  st_q;
    pt_s  st_d;
    logic evt;

    // pick event, keep one of every decim, capture counter
    always_comb begin
        st_d = st_q;
        st_d.gpio = gpio;
        st_d.lost = 1'b0;
        unique case (memclk_pkg::src_e'(source))
            memclk_pkg::SRC_PULSE: evt = recov_pulse;
            memclk_pkg::SRC_ANY:   evt = gpio ^ st_q.gpio;
            memclk_pkg::SRC_RISE:  evt = gpio & ~st_q.gpio;
            memclk_pkg::SRC_FALL:  evt = ~gpio & st_q.gpio;
        endcase
        if (st_q.valid && point_ready) begin
            st_d.valid = 1'b0;
        end
        if (evt) begin
            if (st_q.dcnt == decim - 10'h001) begin
                st_d.dcnt = 10'h000;
                if (st_q.valid && !point_ready) begin
                    st_d.lost = 1'b1;
                end else begin
                    st_d.valid = 1'b1;
                    st_d.ptime = cnt;
                end
            end else begin
                st_d.dcnt = st_q.dcnt + 10'h001;
            end
        end
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign point_valid = st_q.valid;
    assign point_time  = st_q.ptime;
    assign point_lost  = st_q.lost;
endmodule : recovery_point
`default_nettype wire

// ### src/memclk_counter_alarm_recovery.sv
// free counter, two alarms, two clock recovery modules, register port
//
// Functional notes
// [R1] counter advances every clock, low half readable
// [R2] alarm zero flag on first upper-half match
// [R3] alarm one flag on first upper-half match
// [R4] ten-bit decimation, one to 1024 events
// [R5] clear bit low holds divider in reset
// [R6] two-bit source: pulse, any, rise, fall
// [R7] load strobe adopts new divisor, self clears
// [R8] sixteen-bit whole divisor, two to FFFFh
// [R9] sixteen-bit fractional divisor, full range
// [R10] control top three bits read zero
// [R11] control resets to one, whole a two
// [R12] upper counter half readable below low
// [R13] enabled set flag raises interrupt
// [R14] point-lost flag, write one clears
// [R15] divide by whole plus fraction over 65536
// [R16] point captures counter at kept event
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module memclk_counter_alarm_recovery (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    // register port
    input  wire logic [11:0] addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic      [15:0] rdata,
    // interrupt
    output logic             irq,
    // recovery event inputs, index 0 is module a
    input  wire logic [1:0]  recov_pulse,
    input  wire logic [1:0]  gpio,
    // recovered timing ticks
    output logic      [1:0]  recov_tick,
    // point outputs
    input  wire logic [1:0]  point_ready,
    output logic      [1:0]  point_valid,
    output logic      [31:0] point_time_a,
    output logic      [31:0] point_time_b
);
    localparam int CW = memclk_pkg::CTRL_W;

    typedef struct packed {
        logic [31:0]         cnt;
        logic [15:0]         alarm0;
        logic [15:0]         alarm1;
        logic [1:0]          eq;
        logic [1:0][CW-1:0]  ctrl;
        logic [1:0]          load;
        logic [1:0][15:0]    whole;
        logic [1:0][15:0]    frac;
        logic [15:0]         status;
        logic [15:0]         ie;
        logic [15:0]         rdata;
    } top_s;

    top_s        st_q;
    top_s        st_d;
    logic [1:0]  lost;
    logic [1:0]  match;
    logic [15:0] set_v;
    logic [15:0] clr_v;
    logic [31:0] ptime [2];

    // read view of a control register, reserved and strobe bits zero
    function automatic logic [15:0] ctrl_view(input logic [CW-1:0] c);
        ctrl_view = {3'b000, c};
    endfunction : ctrl_view

    // ****************************************
    // recovery modules
    // ****************************************
    for (genvar i = 0; i < 2; i++) begin : g_rec
        recovery_point u_point (
            .sys_clk     (sys_clk),
            .sys_rst     (sys_rst),
            .recov_pulse (recov_pulse[i]),
            .gpio        (gpio[i]),
            .source      (st_q.ctrl[i][memclk_pkg::SRC_LSB+:2]), // R6
            .decim       (st_q.ctrl[i][memclk_pkg::DECIM_W-1:0]), // R4
            .cnt         (st_q.cnt), // R16
            .point_ready (point_ready[i]),
            .point_valid (point_valid[i]),
            .point_time  (ptime[i]),
            .point_lost  (lost[i])
        );
        frac_divider #(
            .WHOLE_RST ((i == 0) ? memclk_pkg::WHOLE_A_RST
                                 : memclk_pkg::WHOLE_B_RST)
        ) u_div (
            .sys_clk  (sys_clk),
            .sys_rst  (sys_rst),
            .clear_n  (st_q.ctrl[i][memclk_pkg::CLR_BIT]), // R5
            .load     (st_q.load[i]), // R7
            .whole_in (st_q.whole[i]), // R8
            .frac_in  (st_q.frac[i]), // R9
            .tick     (recov_tick[i]) // R15
        );
    end

    assign point_time_a = ptime[0];
    assign point_time_b = ptime[1];

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        st_d = st_q;
        st_d.cnt  = st_q.cnt + 32'h0000_0001; // R1
        st_d.load = 2'b00; // R7
        match[0] = (st_q.alarm0 == st_q.cnt[31:16]);
        match[1] = (st_q.alarm1 == st_q.cnt[31:16]);
        st_d.eq = match;
        // first cycle of a match only
        set_v = 16'h0000;
        set_v[memclk_pkg::ALARM0_BIT] = match[0] & ~st_q.eq[0]; // R2
        set_v[memclk_pkg::ALARM1_BIT] = match[1] & ~st_q.eq[1]; // R3
        set_v[memclk_pkg::LOST_A_BIT] = lost[0]; // R14
        set_v[memclk_pkg::LOST_B_BIT] = lost[1]; // R14
        clr_v = 16'h0000;
        // register writes
        if (wr_en) begin
            unique case (addr)
                memclk_pkg::STATUS_ADDR:  clr_v = wdata; // R14
                memclk_pkg::IE_ADDR:
                    st_d.ie = wdata & memclk_pkg::STATUS_MASK;
                memclk_pkg::ALARM0_ADDR:  st_d.alarm0 = wdata; // R2
                memclk_pkg::ALARM1_ADDR:  st_d.alarm1 = wdata; // R3
                memclk_pkg::CTRL_A_ADDR: begin
                    st_d.ctrl[0] = wdata[CW-1:0];
                    st_d.load[0] = wdata[memclk_pkg::LOAD_BIT]; // R7
                end
                memclk_pkg::CTRL_B_ADDR: begin
                    st_d.ctrl[1] = wdata[CW-1:0];
                    st_d.load[1] = wdata[memclk_pkg::LOAD_BIT]; // R7
                end
                memclk_pkg::WHOLE_A_ADDR: st_d.whole[0] = wdata; // R8
                memclk_pkg::FRAC_A_ADDR:  st_d.frac[0]  = wdata; // R9
                memclk_pkg::WHOLE_B_ADDR: st_d.whole[1] = wdata; // R8
                memclk_pkg::FRAC_B_ADDR:  st_d.frac[1]  = wdata; // R9
                default: ;
            endcase
        end
        // register reads, data valid in the next cycle
        st_d.rdata = 16'h0000;
        if (rd_en) begin
            unique case (addr)
                memclk_pkg::STATUS_ADDR: begin
                    st_d.rdata = st_q.status;
                    clr_v      = 16'hFFFF;
                end
                memclk_pkg::IE_ADDR:      st_d.rdata = st_q.ie;
                memclk_pkg::CNT_HI_ADDR:
                    st_d.rdata = st_q.cnt[31:16]; // R12
                memclk_pkg::CNT_LO_ADDR:
                    st_d.rdata = st_q.cnt[15:0]; // R1
                memclk_pkg::ALARM0_ADDR:  st_d.rdata = st_q.alarm0;
                memclk_pkg::ALARM1_ADDR:  st_d.rdata = st_q.alarm1;
                memclk_pkg::CTRL_A_ADDR:
                    st_d.rdata = ctrl_view(st_q.ctrl[0]); // R10
                memclk_pkg::CTRL_B_ADDR:
                    st_d.rdata = ctrl_view(st_q.ctrl[1]); // R10
                memclk_pkg::WHOLE_A_ADDR: st_d.rdata = st_q.whole[0];
                memclk_pkg::FRAC_A_ADDR:  st_d.rdata = st_q.frac[0];
                memclk_pkg::WHOLE_B_ADDR: st_d.rdata = st_q.whole[1];
                memclk_pkg::FRAC_B_ADDR:  st_d.rdata = st_q.frac[1];
                default:                  st_d.rdata = 16'h0000;
            endcase
        end
        // a new event wins over a clear in the same cycle
        st_d.status = ((st_q.status & ~clr_v) | set_v)
                      & memclk_pkg::STATUS_MASK;
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_q          <= '0;
            st_q.ctrl[0]  <= memclk_pkg::CTRL_RST; // R11
            st_q.ctrl[1]  <= memclk_pkg::CTRL_RST; // R11
            st_q.whole[0] <= memclk_pkg::WHOLE_A_RST; // R11
            st_q.whole[1] <= memclk_pkg::WHOLE_B_RST;
            st_q.frac[0]  <= memclk_pkg::FRAC_RST;
            st_q.frac[1]  <= memclk_pkg::FRAC_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // outputs
    assign rdata = st_q.rdata;
    assign irq   = |(st_q.status & st_q.ie); // R13

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    a_cnt_free_run: assert property ( // R1
        !$past(sys_rst) |-> st_q.cnt == $past(st_q.cnt) + 32'h0000_0001)
        else $error("free counter did not advance by one");

    a_cnt_low_read: assert property ( // R1
        rd_en && addr == memclk_pkg::CNT_LO_ADDR
        |=> rdata == $past(st_q.cnt[15:0]))
        else $error("low counter read returned wrong value");

    a_cnt_high_read: assert property ( // R12
        rd_en && addr == memclk_pkg::CNT_HI_ADDR
        |=> rdata == $past(st_q.cnt[31:16]))
        else $error("high counter read returned wrong value");

    a_alarm0_first_match: assert property ( // R2
        st_q.alarm0 == st_q.cnt[31:16] && !st_q.eq[0]
        |=> st_q.status[memclk_pkg::ALARM0_BIT])
        else $error("alarm zero flag not set on match");

    a_alarm1_first_match: assert property ( // R3
        st_q.alarm1 == st_q.cnt[31:16] && !st_q.eq[1]
        |=> st_q.status[memclk_pkg::ALARM1_BIT])
        else $error("alarm one flag not set on match");

    a_ctrl_top_zero: assert property ( // R10
        rd_en && (addr == memclk_pkg::CTRL_A_ADDR ||
                  addr == memclk_pkg::CTRL_B_ADDR)
        |=> rdata[15:13] == 3'b000)
        else $error("control reserved bits read nonzero");

    a_ctrl_reset_val: assert property ( // R11
        $past(sys_rst) |-> st_q.ctrl[0] == memclk_pkg::CTRL_RST
        && st_q.whole[0] == memclk_pkg::WHOLE_A_RST)
        else $error("control or whole divisor reset value wrong");

    a_div_clear_hold: assert property ( // R5
        !st_q.ctrl[0][memclk_pkg::CLR_BIT]
        ##1 !st_q.ctrl[0][memclk_pkg::CLR_BIT] |=> !recov_tick[0])
        else $error("divider ticked while held in reset");

    a_lost_sets_flag: assert property ( // R14
        lost[0] |=> st_q.status[memclk_pkg::LOST_A_BIT])
        else $error("point lost flag not set");

    a_irq_follows: assert property ( // R13
        st_q.status[memclk_pkg::ALARM0_BIT] &&
        st_q.ie[memclk_pkg::ALARM0_BIT] |-> irq)
        else $error("enabled flag did not raise interrupt");

    a_point_capture: assert property ( // R16
        recov_pulse[0] && st_q.ctrl[0] == memclk_pkg::CTRL_RST
        && !point_valid[0] |=> point_valid[0] && point_time_a ==
        $past(st_q.cnt))
        else $error("point did not capture counter");

    a_load_pulse: assert property ( // R7
        st_q.load[0] |=> !st_q.load[0] || $past(wr_en))
        else $error("load strobe held its value");

    c_alarm0_hit:  cover property (st_q.status[memclk_pkg::ALARM0_BIT]);
    c_point_lost:  cover property (lost[1]);
    c_irq_raised:  cover property (irq);
    c_tick_seen:   cover property (recov_tick[0] ##1 recov_tick[1]);

endmodule : memclk_counter_alarm_recovery
`default_nettype wire

// ### test/tb.sv
// self-checking bench for the memory clock counter, alarms and recovery
`timescale 1ns/1ps
`default_nettype none
module tb;
    // ****************************************
    // stimulus and observed signals
    // ****************************************
    logic        sys_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [11:0] addr = 12'h000;
    logic [15:0] wdata = 16'h0000;
    logic        wr_en = 1'b0;
    logic        rd_en = 1'b0;
    logic [15:0] rdata;
    logic        irq;
    logic [1:0]  recov_pulse = 2'h0;
    logic [1:0]  gpio = 2'h0;
    logic [1:0]  recov_tick;
    logic [1:0]  point_ready = 2'h0;
    logic [1:0]  point_valid;
    logic [31:0] point_time_a;
    logic [31:0] point_time_b;
    int          n_mismatch = 0;
    int          checked = 0;
    int          ticks = 0;
    int          ticks_b = 0;
    int          pts_b = 0;
    int          exp_pts [4] = '{4, 5, 3, 2};

    memclk_counter_alarm_recovery memclk_counter_alarm_recovery_inst (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .irq(irq),
        .recov_pulse(recov_pulse), .gpio(gpio), .recov_tick(recov_tick),
        .point_ready(point_ready), .point_valid(point_valid),
        .point_time_a(point_time_a), .point_time_b(point_time_b)
    );

    // clock and event counters
    always #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        ticks = ticks + ((recov_tick[0] === 1'b1) ? 1 : 0);
        ticks_b = ticks_b + ((recov_tick[1] === 1'b1) ? 1 : 0);
        pts_b = pts_b + ((point_valid[1] === 1'b1) ? 1 : 0);
    end

    // ****************************************
    // access and check tasks
    // ****************************************
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            n_mismatch++;
            $display("BAD %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge sys_clk);
        wr_en <= 1'b0;
    endtask : wr

    // read, optionally firing recovery pulses in the same cycle
    task automatic rdp(input logic [11:0] a, input logic [1:0] pm,
                       output logic [15:0] d);
        @(posedge sys_clk);
        addr        <= a;
        rd_en       <= 1'b1;
        recov_pulse <= pm;
        @(posedge sys_clk);
        rd_en       <= 1'b0;
        recov_pulse <= 2'h0;
        @(negedge sys_clk);
        d = rdata;
    endtask : rdp

    task automatic rd_chk(input logic [11:0] a, input logic [15:0] e);
        logic [15:0] d;
        rdp(a, 2'h0, d);
        chk({16'h0000, d}, {16'h0000, e});
    endtask : rd_chk

    task automatic pulse_b();
        @(posedge sys_clk);
        recov_pulse <= 2'h2;
        @(posedge sys_clk);
        recov_pulse <= 2'h0;
        repeat (3) @(posedge sys_clk);
    endtask : pulse_b

    task automatic wait_tick(output int t);
        t = 0;
        for (int i = 0; i < 100 && t == 0; i++) begin
            @(negedge sys_clk);
            if (recov_tick[0] === 1'b1) t = $time / 50;
        end
    endtask : wait_tick

    task automatic tally_and_finish();
        if (n_mismatch == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish

    // watchdog against a hang
    initial begin
        #4_500_000;
        n_mismatch++;
        tally_and_finish();
    end

    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        logic [15:0] v;
        logic [15:0] w;
        int          s;
        int          t0;
        int          t;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        // reset values, unmapped place
        rd_chk(memclk_pkg::CTRL_A_ADDR, 16'h0001);
        rd_chk(memclk_pkg::WHOLE_A_ADDR, 16'h0002);
        rd_chk(memclk_pkg::FRAC_A_ADDR, 16'h0000);
        rd_chk(memclk_pkg::CTRL_B_ADDR, 16'h0001);
        rd_chk(memclk_pkg::ALARM0_ADDR, 16'h0000);
        rd_chk(memclk_pkg::CNT_HI_ADDR, 16'h0000);
        rd_chk(12'h7FE, 16'h0000);
        // both alarms matched zero after reset, read clears them
        chk({31'h0, irq}, 32'h0000_0000);
        rd_chk(memclk_pkg::STATUS_ADDR, 16'h0003);
        rd_chk(memclk_pkg::STATUS_ADDR, 16'h0000);
        // counter low advances one per cycle
        rdp(memclk_pkg::CNT_LO_ADDR, 2'h0, v);
        rdp(memclk_pkg::CNT_LO_ADDR, 2'h0, w);
        chk({16'h0000, w - v}, 32'h0000_0002);
        // alarm zero on upper half reaching one
        wr(memclk_pkg::IE_ADDR, 16'h0001);
        wr(memclk_pkg::ALARM1_ADDR, 16'h0002);
        wr(memclk_pkg::ALARM0_ADDR, 16'h0001);
        for (int i = 0; i < 70000 && irq !== 1'b1; i++) @(negedge sys_clk);
        chk({31'h0, irq}, 32'h0000_0001);
        rd_chk(memclk_pkg::STATUS_ADDR, 16'h0001);
        chk({31'h0, irq}, 32'h0000_0000);
        rd_chk(memclk_pkg::CNT_HI_ADDR, 16'h0001);
        wr(memclk_pkg::ALARM1_ADDR, 16'h0001);
        rd_chk(memclk_pkg::STATUS_ADDR, 16'h0002);
        // point capture on module a, then a refused second point
        wr(memclk_pkg::CTRL_A_ADDR, 16'h0001);
        rdp(memclk_pkg::CNT_LO_ADDR, 2'h1, v);
        chk({31'h0, point_valid[0]}, 32'h0000_0001);
        chk({16'h0000, point_time_a[15:0]}, {16'h0000, v});
        rdp(12'h7FE, 2'h1, w);
        chk({16'h0000, point_time_a[15:0]}, {16'h0000, v});
        rd_chk(memclk_pkg::STATUS_ADDR, 16'h0040);
        rdp(12'h7FE, 2'h1, w);
        wr(memclk_pkg::STATUS_ADDR, 16'h0040);
        rd_chk(memclk_pkg::STATUS_ADDR, 16'h0000);
        point_ready <= 2'h3;
        repeat (2) @(posedge sys_clk);
        chk({31'h0, point_valid[0]}, 32'h0000_0000);
        // every source code of module b
        for (int c = 0; c < 4; c++) begin
            gpio <= 2'h0;
            repeat (3) @(posedge sys_clk);
            wr(memclk_pkg::CTRL_B_ADDR, (16'(c) << 11) | 16'h0001);
            repeat (2) @(posedge sys_clk);
            s = pts_b;
            repeat (4) pulse_b();
            for (int k = 0; k < 5; k++) begin
                gpio[1] <= ~gpio[1];
                repeat (4) @(posedge sys_clk);
            end
            chk(pts_b - s, exp_pts[c]);
        end
        // keep one of every three events
        wr(memclk_pkg::CTRL_B_ADDR, 16'h0003);
        s = pts_b;
        repeat (9) pulse_b();
        chk(pts_b - s, 32'h0000_0003);
        // module b point carries the counter of its event cycle
        wr(memclk_pkg::CTRL_B_ADDR, 16'h0001);
        rdp(memclk_pkg::CNT_LO_ADDR, 2'h2, v);
        chk({16'h0000, point_time_b[15:0]}, {16'h0000, v});
        // divider held while clear is low, then free at whole two
        @(negedge sys_clk) s = ticks;
        repeat (20) @(negedge sys_clk);
        chk(ticks - s, 32'h0000_0000);
        wr(memclk_pkg::CTRL_A_ADDR, 16'h0401);
        wait_tick(t);
        s = ticks;
        repeat (20) @(negedge sys_clk);
        chk(ticks - s, 32'h0000_000A);
        // load whole five and half fraction: 5.5 cycles a period
        wr(memclk_pkg::WHOLE_A_ADDR, 16'h0005);
        wr(memclk_pkg::FRAC_A_ADDR, 16'h8000);
        wr(memclk_pkg::CTRL_A_ADDR, 16'h2401);
        rd_chk(memclk_pkg::CTRL_A_ADDR, 16'h0401);
        rd_chk(memclk_pkg::WHOLE_A_ADDR, 16'h0005);
        rd_chk(memclk_pkg::FRAC_A_ADDR, 16'h8000);
        repeat (2) wait_tick(t);
        wait_tick(t0);
        repeat (20) wait_tick(t);
        chk(t - t0, 32'h0000_006E);
        // reserved and pulse bits read zero
        wr(memclk_pkg::CTRL_B_ADDR, 16'hFFFF);
        rd_chk(memclk_pkg::CTRL_B_ADDR, 16'h1FFF);
        // module b divider runs, whole zero acts as two
        @(negedge sys_clk) s = ticks_b;
        repeat (20) @(negedge sys_clk);
        chk(ticks_b - s, 32'h0000_000A);
        wr(memclk_pkg::WHOLE_A_ADDR, 16'hFFFF);
        rd_chk(memclk_pkg::WHOLE_A_ADDR, 16'hFFFF);
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
